// >>> shared/bgt_cfg.svh
// Constants for the ballast gate timing and protection block.
// How it works
// - Overcurrent level one over 500ns in preheat or run latches shutdown
// - Slope plus level one in preheat starts ignition hold
// - Level two over 500ns in start phases latches
// - No positive current 2500ms in run faults
// - Negative or spike over 620us in run faults
// - Dead time adapts 1.25us to 2.5us
// - Lockout holds all gates low
// - Supply comparator controls lockout entry and exit
// - Start-up pulses 47us off, 4.0us growing on
// - Enough zero-current events switch to variable mode
// - Low load in variable mode switches to gapped conduction
// - Boost current over 200ns ends pulse
// - No zero-current in 52us restarts cycle
// - Zero current detected on hysteretic falling crossing
// - Low line lengthens boost on-time
// - Fault latch clears only on lockout or removal
`ifndef BGT_CFG_SVH
`define BGT_CFG_SVH
`define BGT_CLK_MHZ        100
`define BGT_OC_NS          500
`define BGT_OC_CYC         ((`BGT_OC_NS*`BGT_CLK_MHZ)/1000)
`define BGT_BCS_NS         200
`define BGT_BCS_CYC        ((`BGT_BCS_NS*`BGT_CLK_MHZ)/1000)
`define BGT_CAP2_US        620
`define BGT_CAP2_CYC       (`BGT_CAP2_US*`BGT_CLK_MHZ)
`define BGT_CAP1_MS        2500
`define BGT_CAP1_CYC       (`BGT_CAP1_MS*1000*`BGT_CLK_MHZ)
`define BGT_DT_MIN_NS      1250
`define BGT_DT_MIN_CYC     ((`BGT_DT_MIN_NS*`BGT_CLK_MHZ)/1000)
`define BGT_DT_MAX_NS      2500
`define BGT_DT_MAX_CYC     ((`BGT_DT_MAX_NS*`BGT_CLK_MHZ)/1000)
`define BGT_OFF_US         47
`define BGT_OFF_CYC        (`BGT_OFF_US*`BGT_CLK_MHZ)
`define BGT_ON_MIN_NS      4000
`define BGT_ON_MIN_CYC     ((`BGT_ON_MIN_NS*`BGT_CLK_MHZ)/1000)
`define BGT_ON_MAX_NS      22700
`define BGT_ON_MAX_CYC     ((`BGT_ON_MAX_NS*`BGT_CLK_MHZ)/1000)
`define BGT_RST_US         52
`define BGT_RST_CYC        (`BGT_RST_US*`BGT_CLK_MHZ)
`define BGT_ZCD_NEEDED     4
`define BGT_GAP_CYC        1000
`define BGT_ON_STEP_CYC    10
`define BGT_LOWLINE_CYC    200
`endif

// >>> shared/bgt_pkg.sv
// Types for the ballast gate timing and protection block.
package bgt_pkg;
   typedef enum logic [2:0] {
      BGT_LOCKOUT  = 3'b000,
      BGT_STARTUP  = 3'b001,
      BGT_PREHEAT  = 3'b011,
      BGT_IGNITION = 3'b010,
      BGT_RUN      = 3'b110,
      BGT_FAULT    = 3'b100
   } bgt_mode_type;
   typedef enum logic [1:0] {
      BGT_B_ON   = 2'b00,
      BGT_B_OFF  = 2'b01,
      BGT_B_WAIT = 2'b11
   } bgt_boost_type;
endpackage

// >>> shared/bgt_qual_if.sv
// Interface carrying synchronised comparator levels and qualified results.
`timescale 1ns/1ps
`default_nettype none
interface bgt_qual_if;
   logic oc1;
   logic oc2;
   logic slope;
   logic neg;
   logic spike;
   logic bcs;
   logic zcd_hi;
   logic zcd_lo;
   logic low_line;
   logic oc1_q;
   logic oc2_q;
   logic bcs_q;
   logic zcd_evt;
   modport qual (output oc1, oc2, slope, neg, spike, bcs, zcd_hi, zcd_lo,
                 low_line, oc1_q, oc2_q, bcs_q, zcd_evt);
   modport core (input oc1, oc2, slope, neg, spike, bcs, zcd_hi, zcd_lo,
                 low_line, oc1_q, oc2_q, bcs_q, zcd_evt);
endinterface
`default_nettype wire

// >>> rtl/bgt_input_qual.sv
// Input synchroniser and short qualification timers.
`timescale 1ns/1ps
`default_nettype none
`include "bgt_cfg.svh"
module bgt_input_qual
   import bgt_pkg::*;
#(
   parameter int N = 9
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [N-1:0] raw_i,
   bgt_qual_if.qual          q
);
   // ****************************************************************
   // Synchroniser
   // ****************************************************************
   logic [N-1:0] meta;
   logic [N-1:0] sync;
   always_ff @(posedge clk_i) begin
      meta <= raw_i;
      sync <= meta;
   end
   assign q.oc1      = sync[0];
   assign q.oc2      = sync[1];
   assign q.slope    = sync[2];
   assign q.neg      = sync[3];
   assign q.spike    = sync[4];
   assign q.bcs      = sync[5];
   assign q.zcd_hi   = sync[6];
   assign q.zcd_lo   = sync[7];
   assign q.low_line = sync[8];
   // ****************************************************************
   // Qualification counters
   // ****************************************************************
   logic [7:0] c_oc1;
   logic [7:0] c_oc2;
   logic [7:0] c_bcs;
   logic       armed;
   logic       zcd_evt;
   assign q.oc1_q   = (c_oc1 > 8'(`BGT_OC_CYC));
   assign q.oc2_q   = (c_oc2 > 8'(`BGT_OC_CYC));
   assign q.bcs_q   = (c_bcs > 8'(`BGT_BCS_CYC));
   assign q.zcd_evt = zcd_evt;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         c_oc1   <= 8'h00;
         c_oc2   <= 8'h00;
         c_bcs   <= 8'h00;
         armed   <= 1'b0;
         zcd_evt <= 1'b0;
      end else begin
         c_oc1 <= !sync[0] ? 8'h00 : (&c_oc1 ? c_oc1 : c_oc1 + 8'h01);
         c_oc2 <= !sync[1] ? 8'h00 : (&c_oc2 ? c_oc2 : c_oc2 + 8'h01);
         c_bcs <= !sync[5] ? 8'h00 : (&c_bcs ? c_bcs : c_bcs + 8'h01);
         // Arm above the upper level, fire once on dropping below the lower.
         if (sync[6]) begin
            armed <= 1'b1;
         end else if (armed && !sync[7]) begin
            armed <= 1'b0;
         end
         zcd_evt <= armed && !sync[6] && !sync[7];
      end
   end
endmodule
`default_nettype wire

// >>> rtl/bgt_top.sv
// Gate timing and protection core for the ballast controller.
`timescale 1ns/1ps
`default_nettype none
`include "bgt_cfg.svh"
module bgt_top
   import bgt_pkg::*;
#(
   parameter int CAP1_CYC = `BGT_CAP1_CYC,
   parameter int CAP2_CYC = `BGT_CAP2_CYC,
   parameter int OFF_CYC  = `BGT_OFF_CYC,
   parameter int RST_CYC  = `BGT_RST_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic supply_ok_i,
   input  wire logic preheat_i,
   input  wire logic run_i,
   input  wire logic half_period_i,
   input  wire logic lamp_removed_i,
   input  wire logic low_load_i,
   input  wire logic oc1_cmp_i,
   input  wire logic oc2_cmp_i,
   input  wire logic slope_cmp_i,
   input  wire logic pos_cmp_i,
   input  wire logic neg_cmp_i,
   input  wire logic spike_cmp_i,
   input  wire logic boost_cs_cmp_i,
   input  wire logic zcd_hi_cmp_i,
   input  wire logic zcd_lo_cmp_i,
   input  wire logic low_line_i,
   output logic      low_side_gate_out_o,
   output logic      high_side_gate_out_o,
   output logic      boost_gate_out_o,
   output logic      ignition_hold_o,
   output logic      fault_o,
   output logic      variable_mode_o,
   output logic      gapped_o
);
   bgt_qual_if q ();
   bgt_input_qual #(.N(9)) u_qual (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .raw_i   ({low_line_i, zcd_lo_cmp_i, zcd_hi_cmp_i, boost_cs_cmp_i,
                 spike_cmp_i, neg_cmp_i, slope_cmp_i, oc2_cmp_i,
                 oc1_cmp_i}),
      .q       (q)
   );
   // Positive-level and window inputs are synchronised locally.
   logic [1:0] pos_s;
   logic [1:0] hp_s;
   always_ff @(posedge clk_i) begin
      pos_s <= {pos_s[0], pos_cmp_i};
      hp_s  <= {hp_s[0], half_period_i};
   end
   // ****************************************************************
   // Mode control
   // ****************************************************************
   bgt_mode_type mode;
   bgt_mode_type next_mode;
   logic         lockout;
   logic [31:0]  cap1_cnt;
   logic [31:0]  cap2_cnt;
   logic [31:0]  spk_cnt;
   logic [2:0]   ls_phase;
   wire logic cap_fault = (cap1_cnt > 32'(CAP1_CYC))
                       || (cap2_cnt > 32'(CAP2_CYC))
                       || (spk_cnt > 32'(CAP2_CYC));
   wire logic in_start = (mode == BGT_STARTUP) || (mode == BGT_IGNITION);
   wire logic latch_hit = (q.oc1_q && (mode == BGT_PREHEAT || mode == BGT_RUN))
                        || (q.oc2_q && in_start)
                        || (cap_fault && mode == BGT_RUN);
   wire logic gates_on = !lockout && mode != BGT_FAULT;
   always_comb begin
      next_mode = mode;
      unique case (mode)
         BGT_LOCKOUT:  if (supply_ok_i) next_mode = BGT_STARTUP;
         BGT_STARTUP:  if (preheat_i) next_mode = BGT_PREHEAT;
         BGT_PREHEAT:  if (q.slope && q.oc1) next_mode = BGT_IGNITION;
         BGT_IGNITION: if (run_i) next_mode = BGT_RUN;
         BGT_RUN:      next_mode = BGT_RUN;
         BGT_FAULT:    if (lamp_removed_i) next_mode = BGT_STARTUP;
      endcase
      if (latch_hit) next_mode = BGT_FAULT;
      if (!supply_ok_i) next_mode = BGT_LOCKOUT;
   end
   assign lockout = (mode == BGT_LOCKOUT);
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode <= BGT_LOCKOUT;
      end else begin
         mode <= next_mode;
      end
   end
   // ****************************************************************
   // Capacitive mode watchdogs
   // ****************************************************************
   // Each watchdog runs from the last clean look through its own window.
   // The windows are short, so a fault seen only inside them still adds
   // up to the full time instead of being cleared between windows.
   wire logic pos_ok = low_side_gate_out_o && hp_s[1] && pos_s[1];
   wire logic neg_ok = (ls_phase == 3'h1) && !q.neg;
   wire logic spk_ok = high_side_gate_out_o && !q.spike;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || mode != BGT_RUN) begin
         cap1_cnt <= 32'h0;
         cap2_cnt <= 32'h0;
         spk_cnt  <= 32'h0;
      end else begin
         cap1_cnt <= pos_ok ? 32'h0 : cap1_cnt + 32'h1;
         cap2_cnt <= neg_ok ? 32'h0 : cap2_cnt + 32'h1;
         spk_cnt  <= spk_ok ? 32'h0 : spk_cnt + 32'h1;
      end
   end
   // ****************************************************************
   // Half-bridge dead time
   // ****************************************************************
   // Dead time shrinks while the negative level is seen at the end of
   // the dead time after either gate turns off, else grows; bounded both ways.
   logic [7:0] dead;
   logic [7:0] dt_cnt;
   logic       hs_next;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !gates_on) begin
         low_side_gate_out_o  <= 1'b0;
         high_side_gate_out_o <= 1'b0;
         ls_phase <= 3'h0;
         dead     <= 8'(`BGT_DT_MAX_CYC);
         dt_cnt   <= 8'h00;
         hs_next  <= 1'b0;
      end else begin
         unique case (ls_phase)
            3'h0: begin
               if (hp_s[1] != hp_s[0]) begin
                  low_side_gate_out_o  <= 1'b0;
                  high_side_gate_out_o <= 1'b0;
                  hs_next  <= !hp_s[0];
                  dt_cnt   <= 8'h00;
                  ls_phase <= 3'h1;
               end
            end
            3'h1: begin
               dt_cnt <= dt_cnt + 8'h01;
               if (dt_cnt >= dead) begin
                  low_side_gate_out_o  <= !hs_next;
                  high_side_gate_out_o <= hs_next;
                  ls_phase <= 3'h0;
                  if (q.neg && dead > 8'(`BGT_DT_MIN_CYC)) begin
                     dead <= dead - 8'h01;
                  end else if (!q.neg && dead < 8'(`BGT_DT_MAX_CYC)) begin
                     dead <= dead + 8'h01;
                  end
               end
            end
            default: ls_phase <= 3'h0;
         endcase
      end
   end
   // ****************************************************************
   // Boost gate timing
   // ****************************************************************
   bgt_boost_type bst;
   logic [15:0]   b_cnt;
   logic [15:0]   on_len;
   logic [3:0]    zcd_cnt;
   logic          gap;
   wire logic var_mode = (zcd_cnt >= 4'(`BGT_ZCD_NEEDED));
   wire logic [15:0] on_target = q.low_line
      ? on_len + 16'(`BGT_LOWLINE_CYC) : on_len;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !gates_on) begin
         bst              <= BGT_B_OFF;
         b_cnt            <= 16'h0;
         on_len           <= 16'(`BGT_ON_MIN_CYC);
         zcd_cnt          <= 4'h0;
         gap              <= 1'b0;
         boost_gate_out_o <= 1'b0;
      end else begin
         b_cnt <= b_cnt + 16'h1;
         if (q.zcd_evt && !var_mode) zcd_cnt <= zcd_cnt + 4'h1;
         gap <= low_load_i;
         unique case (bst)
            BGT_B_ON: begin
               if (q.bcs_q || b_cnt >= on_target) begin
                  boost_gate_out_o <= 1'b0;
                  b_cnt <= 16'h0;
                  bst   <= var_mode ? BGT_B_WAIT : BGT_B_OFF;
                  if (on_len < 16'(`BGT_ON_MAX_CYC)) begin
                     on_len <= on_len + 16'(`BGT_ON_STEP_CYC);
                  end
               end
            end
            BGT_B_OFF: begin
               if (b_cnt >= 16'(OFF_CYC)) begin
                  boost_gate_out_o <= 1'b1;
                  b_cnt <= 16'h0;
                  bst   <= BGT_B_ON;
               end
            end
            BGT_B_WAIT: begin
               // Gapped mode ignores the event and waits a fixed idle time from the end of the pulse.
               if ((q.zcd_evt && !gap) || (gap && b_cnt >= 16'(`BGT_GAP_CYC))
                   || b_cnt >= 16'(RST_CYC)) begin
                  boost_gate_out_o <= 1'b1;
                  b_cnt <= 16'h0;
                  bst   <= BGT_B_ON;
               end
            end
            default: bst <= BGT_B_OFF;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ignition_hold_o <= 1'b0;
         fault_o         <= 1'b0;
         variable_mode_o <= 1'b0;
         gapped_o        <= 1'b0;
      end else begin
         ignition_hold_o <= (mode == BGT_IGNITION);
         fault_o         <= (mode == BGT_FAULT);
         variable_mode_o <= var_mode;
         gapped_o        <= gap && var_mode;
      end
   end
endmodule
`default_nettype wire

// >>> tb/bgt_top_checker.sv
// Assertion checker bound to the ballast gate timing core.
`timescale 1ns/1ps
`default_nettype none
module bgt_top_checker #(
   parameter int OFF_CYC = 50,
   parameter int RST_CYC = 60
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic supply_ok_i,
   input wire logic run_i,
   input wire logic lamp_removed_i,
   input wire logic oc1_cmp_i,
   input wire logic boost_cs_cmp_i,
   input wire logic low_side_gate_out_o,
   input wire logic high_side_gate_out_o,
   input wire logic boost_gate_out_o,
   input wire logic fault_o,
   input wire logic variable_mode_o,
   input wire logic gapped_o
);
   // *****
   // Helper counters.
   // *****
   localparam int DT_MIN = 125;
   logic [15:0] idle_cnt;
   logic [15:0] off_cnt;
   logic [7:0]  bcs_cnt;
   logic [7:0]  oc_cnt;
   logic [5:0]  clr_hist;
   logic        gap_seen;
   wire  logic  gates_low = !(low_side_gate_out_o || high_side_gate_out_o
                              || boost_gate_out_o);
   // A gap started under low load may outlast the flag, so skip that span.
   wire  logic  off_ok = supply_ok_i && !fault_o && !gapped_o && !gap_seen;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         idle_cnt <= '1;
         off_cnt  <= '0;
         bcs_cnt  <= '0;
         oc_cnt   <= '0;
         clr_hist <= '1;
         gap_seen <= 1'b0;
      end else begin
         idle_cnt <= (low_side_gate_out_o || high_side_gate_out_o) ? '0 :
                     idle_cnt + 16'(idle_cnt != '1);
         off_cnt  <= (!boost_gate_out_o && off_ok) ? off_cnt + 16'h0001 : '0;
         bcs_cnt  <= boost_cs_cmp_i ? bcs_cnt + 8'(bcs_cnt != 8'hff) : '0;
         oc_cnt   <= (oc1_cmp_i && run_i) ? oc_cnt + 8'(oc_cnt != 8'hff) : '0;
         clr_hist <= {clr_hist[4:0], !supply_ok_i || lamp_removed_i};
         gap_seen <= gapped_o || (gap_seen && !boost_gate_out_o);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_lockout_low; (!supply_ok_i) [*6] |-> gates_low; endproperty
   a_lockout_low: assert property (p_lockout_low)
      else $error("gate driven during supply lockout");
   property p_fault_gates; fault_o && $past(fault_o) |-> gates_low; endproperty
   a_fault_gates: assert property (p_fault_gates)
      else $error("gate driven in fault mode");
   property p_fault_hold; $fell(fault_o) |-> |clr_hist; endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault cleared without lockout or lamp removal");
   property p_dead_time;
      $rose(high_side_gate_out_o) || $rose(low_side_gate_out_o)
         |-> idle_cnt >= DT_MIN;
   endproperty
   a_dead_time: assert property (p_dead_time)
      else $error("dead time between half bridge gates too short");
   property p_bcs_cut; bcs_cnt >= 8'd26 |-> !boost_gate_out_o; endproperty
   a_bcs_cut: assert property (p_bcs_cut)
      else $error("boost pulse not ended by current limit");
   property p_oc1_fault; oc_cnt == 8'd60 |-> ##[0:4] fault_o; endproperty
   a_oc1_fault: assert property (p_oc1_fault)
      else $error("inverter overcurrent not latched");
   property p_restart; off_cnt <= 16'(RST_CYC + 8); endproperty
   a_restart: assert property (p_restart)
      else $error("restart timer did not start a boost cycle");
   property p_fixed_off;
      $rose(boost_gate_out_o) && !variable_mode_o
         |-> (off_cnt >= 16'(OFF_CYC)) or (##[0:2] variable_mode_o);
   endproperty
   a_fixed_off: assert property (p_fixed_off)
      else $error("fixed boost off time too short");
endmodule
bind bgt_top bgt_top_checker #(.OFF_CYC(OFF_CYC), .RST_CYC(RST_CYC)) chk_u (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i), .run_i(run_i),
   .lamp_removed_i(lamp_removed_i), .oc1_cmp_i(oc1_cmp_i),
   .boost_cs_cmp_i(boost_cs_cmp_i), .low_side_gate_out_o(low_side_gate_out_o),
   .high_side_gate_out_o(high_side_gate_out_o), .fault_o(fault_o),
   .boost_gate_out_o(boost_gate_out_o), .variable_mode_o(variable_mode_o),
   .gapped_o(gapped_o));
`default_nettype wire

// >>> tb/bgt_boost_model.sv
// Behavioural model of the boost switch, choke winding and shunt.
`timescale 1ns/1ps
`default_nettype none
module bgt_boost_model (
   input  wire logic        clk_i,
   input  wire logic        gate_i,
   input  wire logic [7:0]  zcd_dly_i,
   input  wire logic [11:0] cs_lim_i,
   output logic             zcd_hi_o,
   output logic             zcd_lo_o,
   output logic             cs_o
);
   // *****
   // Choke discharge and current ramp.
   // *****
   logic [11:0] on_cnt = '0;
   logic [7:0]  off_cnt = 8'hff;
   logic [8:0]  dly;
   assign dly = {1'b0, zcd_dly_i};
   always @(posedge clk_i) begin
      on_cnt  <= (gate_i === 1'b1) ? on_cnt + 12'h001 : 12'h000;
      off_cnt <= (gate_i === 1'b1) ? 8'h00 : off_cnt + 8'(off_cnt != 8'hff);
      // A zero delay means a winding too weak to show any crossing.
      zcd_hi_o <= !gate_i && dly != 0 && {1'b0, off_cnt} < dly;
      zcd_lo_o <= !gate_i && dly != 0 && {1'b0, off_cnt} < dly + 9'h002;
      cs_o     <= gate_i && cs_lim_i != 0 && on_cnt >= cs_lim_i;
   end
endmodule
`default_nettype wire

// >>> tb/ballast_gate_timing_and_protection_bench.sv
// Self-checking bench for the ballast gate timing core.
`timescale 1ns/1ps
`default_nettype none
module ballast_gate_timing_and_protection_bench;
   localparam int OFF = 50;
   localparam int RST = 60;
   logic clk_i = 1'b0, rst_n_i = 1'b0, sup = 1'b0, ph = 1'b0, run = 1'b0;
   logic hp = 1'b0, lr = 1'b0, ll = 1'b0, lline = 1'b0;
   logic zhi, zlo, bcs, lsg, hsg, bg, ign, flt, vm, gap;
   logic [5:0]  stim = 6'h00;
   logic [7:0]  zdly = 8'd12;
   logic [11:0] cslim = 12'd0;
   integer      seed = 32'hc7c7ad0c;
   int          num_errors = 0, samples_checked = 0, cycles = 0, n0, n1;
   always #5 clk_i = ~clk_i;
   bgt_top #(.CAP1_CYC(2000), .CAP2_CYC(2000), .OFF_CYC(OFF), .RST_CYC(RST))
   dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .supply_ok_i(sup), .preheat_i(ph),
      .run_i(run), .half_period_i(hp), .lamp_removed_i(lr), .low_load_i(ll),
      .oc1_cmp_i(stim[0]), .oc2_cmp_i(stim[1]), .slope_cmp_i(stim[5]),
      .pos_cmp_i(hp && !stim[4]), .neg_cmp_i(stim[2]), .spike_cmp_i(stim[3]),
      .boost_cs_cmp_i(bcs), .zcd_hi_cmp_i(zhi), .zcd_lo_cmp_i(zlo),
      .low_line_i(lline), .low_side_gate_out_o(lsg), .ignition_hold_o(ign),
      .high_side_gate_out_o(hsg), .boost_gate_out_o(bg), .fault_o(flt),
      .variable_mode_o(vm), .gapped_o(gap));
   bgt_boost_model model_u (.clk_i(clk_i), .gate_i(bg), .zcd_dly_i(zdly),
      .cs_lim_i(cslim), .zcd_hi_o(zhi), .zcd_lo_o(zlo), .cs_o(bcs));
   // *****
   // Shared tasks.
   // *****
   function automatic logic exp_fault(input int held, input int lim);
      return held > lim + 2;
   endfunction
   task automatic final_report();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wait_for(ref logic s, input logic v, input int lim,
                           input string what);
      for (int i = 0; i < lim && s !== v; i++) tick(1);
      chk(what, v, s);
   endtask
   task automatic span(input logic lvl, output int n);
      wait_for(bg, !lvl, 3000, "boost edge");
      wait_for(bg, lvl, 3000, "boost edge");
      for (n = 0; n < 5000 && bg === lvl; n++) tick(1);
   endtask
   // Only one stimulus pattern is active at a time; release clears them all.
   task automatic pulse(input logic [5:0] m, input int n);
      @(posedge clk_i) stim <= m;
      repeat (n) @(posedge clk_i);
      stim <= 6'h00;
      tick(8);
   endtask
   task automatic power(input logic go_run);
      @(posedge clk_i) begin sup <= 1'b0; ph <= 1'b0; run <= 1'b0; end
      tick(10);
      chk("gates in lockout", 1'b0, lsg | hsg | bg);
      chk("fault after lockout", 1'b0, flt);
      @(posedge clk_i) sup <= 1'b1;
      tick(30);
      if (go_run) begin
         @(posedge clk_i) ph <= 1'b1;
         tick(30);
         pulse(6'h21, 10);
         @(posedge clk_i) begin ph <= 1'b0; run <= 1'b1; end
         tick(300);
      end
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (run && cycles % 300 == 0) hp <= ~hp;
      if (cycles == 60000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      tick(1);
      chk("outputs after reset", 1'b0, lsg|hsg|bg|ign|flt|vm|gap);
      power(1'b0);
      wait_for(bg, 1'b1, OFF, "first boost pulse");
      span(1'b1, n0);
      chk("start on-time", 1'b1, n0 >= 390 && n0 <= 2470);
      wait_for(vm, 1'b1, 4000, "variable mode");
      @(posedge clk_i) zdly <= 8'd0;
      span(1'b0, n0);
      span(1'b0, n0);
      chk("restart gap", 1'b1, n0 <= RST + 8);
      @(posedge clk_i) begin
         zdly  <= 8'd12;
         cslim <= 12'(100 + {$random(seed)} % 50);
      end
      span(1'b1, n0);
      span(1'b1, n0);
      chk("limited on-time", 1'b1, n0 <= int'(cslim) + 26);
      @(posedge clk_i) cslim <= 12'd0;
      span(1'b1, n0);
      @(posedge clk_i) lline <= 1'b1;
      span(1'b1, n1);
      span(1'b1, n1);
      chk("low line on-time", 1'b1, n1 >= n0 + 150);
      @(posedge clk_i) begin lline <= 1'b0; ll <= 1'b1; end
      wait_for(gap, 1'b1, 3000, "gapped set");
      @(posedge clk_i) ll <= 1'b0;
      wait_for(gap, 1'b0, 3000, "gapped clear");
      @(posedge clk_i) ph <= 1'b1;
      tick(30);
      pulse(6'h21, 10);
      chk("ignition hold", 1'b1, ign);
      @(posedge clk_i) begin ph <= 1'b0; run <= 1'b1; end
      tick(300);
      for (int i = 0; i < 4; i++) begin
         n0 = 5 + {$random(seed)} % 40;
         pulse(6'h01, n0);
         chk("short overcurrent", exp_fault(n0, 50), flt);
      end
      pulse(6'h01, 60);
      chk("long overcurrent", exp_fault(60, 50), flt);
      tick(200);
      chk("fault held", 1'b1, flt);
      @(posedge clk_i) lr <= 1'b1;
      tick(5);
      @(posedge clk_i) lr <= 1'b0;
      wait_for(flt, 1'b0, 20, "fault cleared");
      for (int k = 0; k < 3; k++) begin
         n1 = 2000;
         power(1'b1);
         pulse(6'h04 << k, n1 - 1500);
         chk("short run fault", exp_fault(n1 - 1500, n1), flt);
         pulse(6'h04 << k, n1 + 30);
         chk("long run fault", exp_fault(n1 + 30, n1), flt);
      end
      power(1'b0);
      pulse(6'h02, 30);
      chk("short level two", exp_fault(30, 50), flt);
      pulse(6'h02, 60);
      chk("long level two", exp_fault(60, 50), flt);
      power(1'b0);
      final_report();
   end
endmodule
`default_nettype wire
